// file: mcb_defines.vh
`ifndef MCB_DEFINES_VH
`define MCB_DEFINES_VH
// model-register addresses
`define MCB_BANK0_ADDR       12'h400
`define MCB_BANK_STRIDE      12'h004
`define MCB_GSTATUS_ADDR     12'h17A
`define MCB_CAP_ADDR         12'h179
`define MCB_LEG_LOC_ADDR     12'h000
`define MCB_LEG_KIND_ADDR    12'h001
// register slot inside a bank
`define MCB_SLOT_STATUS      2'h1
`define MCB_SLOT_LOC         2'h2
`define MCB_SLOT_EXTRA       2'h3
// status field positions
`define MCB_ST_ENTRY         63
`define MCB_ST_LOST          62
`define MCB_ST_NOTFIXED      61
`define MCB_ST_EXTRA         59
`define MCB_ST_LOC           58
`define MCB_ST_CTXBAD        57
// global status field positions
`define MCB_GS_RESTART       0
`define MCB_GS_INPROG        2
// capability presence bit for the bank architecture
`define MCB_CAP_ARCH         9
// reset values
`define MCB_RST_64           64'h0000000000000000
`endif

// file: mcb_bank.v
`timescale 1ns/1ps
`include "mcb_defines.vh"
// one error bank: holds a single logged entry
module mcb_bank
(
	input  wire        core_clk,
	input  wire        srst,
	input  wire        err_valid,     // error report pulse
	input  wire [63:0] err_status,    // status incl. flags
	input  wire [63:0] err_loc,       // fault location
	input  wire [63:0] err_extra,     // extra information
	input  wire        clr_wr,        // software write of zeros to status
	output reg  [63:0] status_q,
	output reg  [63:0] loc_q,
	output reg  [63:0] extra_q
);
	// capture and clear of the single entry
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			status_q <= `MCB_RST_64;
			loc_q    <= `MCB_RST_64;
			extra_q  <= `MCB_RST_64;
		end
		else if (err_valid && (!status_q[`MCB_ST_ENTRY] || clr_wr))
		begin
			status_q <= err_status | (64'h1 << `MCB_ST_ENTRY);
			loc_q    <= err_loc;
			extra_q  <= err_extra;
		end
		else if (err_valid)
			status_q[`MCB_ST_LOST] <= 1'b1;
		else if (clr_wr)
			status_q <= `MCB_RST_64;
	end
endmodule

// file: mcb_top.v
`timescale 1ns/1ps
`include "mcb_defines.vh"
// What this block does
// - corrected errors logged, no exception raised
// - location flag marks location register valid
// - extra-info flag marks extra register valid
// - zero write clears lost and present
// - next error loads after clear
// - in-progress flag set during exception
// - restartable needs clean context and restart-ok
// - legacy kind/location readable when trap enabled
// - legacy registers undefined with bank architecture
// - one logged error per bank
// - bank zero at 400H, count in capability
// - not-fixed flag tells uncorrected error
module mcb_top
#(
	parameter NBANK = 4
)
(
	input  wire             core_clk,
	input  wire             srst,
	input  wire [NBANK-1:0] err_valid,            // per-bank error pulse
	input  wire             err_not_fixed,        // error was not corrected
	input  wire             err_ctx_bad,          // context corrupt
	input  wire             err_has_loc,          // location valid
	input  wire             err_has_extra,        // extra info valid
	input  wire [15:0]      err_code,             // error code
	input  wire [63:0]      err_loc,              // fault address
	input  wire [63:0]      err_extra,            // extra information
	input  wire             err_restart_ok,       // restart point valid
	input  wire             check_trap_enable,    // control_register_four trap bit
	input  wire             arch_present,         // bank architecture implemented
	input  wire             msr_rd,               // model_reg_read_op strobe
	input  wire             msr_wr,               // model register write strobe
	input  wire [11:0]      msr_addr,             // register address
	input  wire [63:0]      msr_wdata,            // write data
	input  wire             exc_done,             // handler return
	output reg  [63:0]      msr_rdata,            // read data
	output reg              msr_rvalid,           // read answer pulse
	output reg              mc_exception,         // exception request pulse
	output wire             exception_in_progress_flag,
	output wire             restartable           // current restart verdict
);
	reg  [63:0] gstat_q;       // global check status
	reg  [63:0] leg_kind_q;    // legacy error kind
	reg  [63:0] leg_loc_q;     // legacy error location
	reg  [NBANK-1:0] prev_ctx_q; // context-corrupt of last uncorrected error
	wire [64*NBANK-1:0] st_w;  // all bank status words, bank 0 lowest
	wire [64*NBANK-1:0] lo_w;  // all bank location words
	wire [64*NBANK-1:0] ex_w;  // all bank extra-information words
	wire [63:0] new_status;    // status word built from the error qualifiers
	wire        any_err;       // some bank reports an error this cycle
	wire        uncorr;        // the report is an uncorrected error
	reg  [63:0] rd_mux;        // read data chosen from the address this cycle
	integer     rb;            // bank loop index of the read mux

	// bank count held at 32 bits so the capability field can slice it
	localparam [31:0] NBANK_32 = NBANK;

	// bank index and slot decode shared by read and write
	// the offset wraps in 13 bits, so addresses below the bank window
	// turn into large values and never alias a bank slot
	function [12:0] bank_hit;
		input [11:0] a;
		input integer b;
		integer span;
		begin
			span = b * 4;
			bank_hit = {1'b0, a} - {1'b0, `MCB_BANK0_ADDR} - span[12:0];
		end
	endfunction

	assign new_status = {1'b0, 1'b0, err_not_fixed, 1'b0, err_has_extra, err_has_loc,
		err_ctx_bad, 41'h0, err_code};
	// the qualifiers are shared by all banks; only one report is
	// expected per cycle, so a shared status word costs nothing
	assign any_err = |err_valid;
	// corrected errors silent
	// corrected errors are still logged by the bank, they only skip
	// the exception request and the global status, context and legacy updates
	assign uncorr = any_err & err_not_fixed;

	genvar g;
	generate
		for (g = 0; g < NBANK; g = g + 1)
		begin : bank
			// clearing write aimed at this bank's status slot
			wire clr;
			// a nonzero write is ignored on purpose: software may only
			// retire an entry, never forge one
			// only full zero write clears
			assign clr = msr_wr && (msr_wdata == 64'h0) &&
				(bank_hit(msr_addr, g) == {11'h0, `MCB_SLOT_STATUS});
			mcb_bank u_bank
			(
				.core_clk   (core_clk),
				.srst       (srst),
				.err_valid  (err_valid[g]),
				.err_status (new_status),
				.err_loc    (err_loc),
				.err_extra  (err_extra),
				.clr_wr     (clr),
				.status_q   (st_w[64*g +: 64]),
				.loc_q      (lo_w[64*g +: 64]),
				.extra_q    (ex_w[64*g +: 64])
			);
		end
	endgenerate

	// global status, exception request and legacy capture
	// a new uncorrected error wins over a software write or a handler
	// return in the same cycle, so the in-progress mark is never lost
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			gstat_q      <= `MCB_RST_64;
			leg_kind_q   <= `MCB_RST_64;
			leg_loc_q    <= `MCB_RST_64;
			prev_ctx_q   <= {NBANK{1'b0}};
			mc_exception <= 1'b0;
		end
		else
		begin
			mc_exception <= uncorr;
			if (uncorr)
			begin
				gstat_q[`MCB_GS_INPROG]  <= 1'b1;
				gstat_q[`MCB_GS_RESTART] <= err_restart_ok;
				prev_ctx_q <= err_valid & {NBANK{err_ctx_bad}};
				leg_kind_q <= {48'h0, err_code};
				leg_loc_q  <= err_loc;
			end
			// software writes global status, e.g. clearing in-progress
			else if (msr_wr && msr_addr == `MCB_GSTATUS_ADDR)
				gstat_q <= msr_wdata;
			else if (exc_done)
				gstat_q[`MCB_GS_INPROG] <= 1'b0;
		end
	end

	assign exception_in_progress_flag = gstat_q[`MCB_GS_INPROG];
	assign restartable = gstat_q[`MCB_GS_RESTART] & ~(|prev_ctx_q);

	// read data selection from the address alone
	// unmapped addresses and slot zero of every bank read as zero
	always @*
	begin
		rd_mux = 64'h0;
		if (msr_addr == `MCB_CAP_ADDR)
			rd_mux = {54'h0, arch_present, 1'b0, NBANK_32[7:0]};
		// global status as last set by an error, a handler return or software
		else if (msr_addr == `MCB_GSTATUS_ADDR)
			rd_mux = gstat_q;
		// invalid with architecture
		// the legacy pair reads zero rather than stale data when the
		// bank architecture is present or the trap is disabled
		else if (msr_addr == `MCB_LEG_KIND_ADDR)
			rd_mux = (check_trap_enable && !arch_present) ? leg_kind_q : 64'h0;
		else if (msr_addr == `MCB_LEG_LOC_ADDR)
			rd_mux = (check_trap_enable && !arch_present) ? leg_loc_q : 64'h0;
		// bank slots; at most one bank can match a given address
		for (rb = 0; rb < NBANK; rb = rb + 1)
		begin
			// status slot
			if (bank_hit(msr_addr, rb) == {11'h0, `MCB_SLOT_STATUS})
				rd_mux = st_w[64*rb +: 64];
			// location slot
			else if (bank_hit(msr_addr, rb) == {11'h0, `MCB_SLOT_LOC})
				rd_mux = lo_w[64*rb +: 64];
			// extra-information slot
			else if (bank_hit(msr_addr, rb) == {11'h0, `MCB_SLOT_EXTRA})
				rd_mux = ex_w[64*rb +: 64];
		end
	end

	// read port, one cycle latency
	// the data register follows the address every cycle; only the valid
	// pulse tells software which cycle carries its answer
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			msr_rdata  <= `MCB_RST_64;
			msr_rvalid <= 1'b0;
		end
		else
		begin
			msr_rdata  <= rd_mux;
			msr_rvalid <= msr_rd;
		end
	end
endmodule

// file: mcb_top_sva.sv
`timescale 1ns/1ps
// watches only the top ports
module mcb_top_chk
#(
	parameter NBANK = 4
)
(
	input wire             core_clk,
	input wire             srst,
	input wire [NBANK-1:0] err_valid,
	input wire             err_not_fixed,
	input wire             check_trap_enable,
	input wire             arch_present,
	input wire             msr_rd,
	input wire             msr_wr,
	input wire [11:0]      msr_addr,
	input wire [63:0]      msr_wdata,
	input wire             exc_done,
	input wire [63:0]      msr_rdata,
	input wire             msr_rvalid,
	input wire             mc_exception,
	input wire             exception_in_progress_flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// zero write to bank 0 status, no new error racing it
	sequence s_clr; msr_wr && msr_addr == 12'h401 && msr_wdata == 64'h0 && !err_valid[0]; endsequence
	sequence s_rd0; msr_rd && msr_addr == 12'h401; endsequence
	a_clear_reads_zero: assert property (s_clr ##1 s_rd0 |=> msr_rdata[63:62] == 2'h0)
		else $error("cleared status still flagged");
	a_fixed_quiet: assert property (|err_valid && !err_not_fixed |=> !mc_exception)
		else $error("exception on corrected error");
	a_unfixed_raise: assert property (|err_valid && err_not_fixed |=> mc_exception)
		else $error("no exception on uncorrected error");
	a_inprog_set: assert property (mc_exception |-> exception_in_progress_flag)
		else $error("in-progress missing");
	a_inprog_drop: assert property (exc_done && !(|err_valid) |=> !exception_in_progress_flag)
		else $error("in-progress stuck");
	a_read_answer: assert property (msr_rd |=> msr_rvalid)
		else $error("read unanswered");
	a_no_stray: assert property (!msr_rd |=> !msr_rvalid)
		else $error("stray read answer");
	a_legacy_blank: assert property (msr_rd && msr_addr[11:1] == 11'h0 && (!check_trap_enable
		|| arch_present) |=> msr_rdata == 64'h0)
		else $error("legacy read not blank");
	a_empty_slot: assert property (msr_rd && msr_addr == 12'h400 |=> msr_rdata == 64'h0)
		else $error("slot zero not blank");
endmodule
bind mcb_top mcb_top_chk #(.NBANK(NBANK)) u_chk (.core_clk(core_clk), .srst(srst),
	.err_valid(err_valid), .err_not_fixed(err_not_fixed), .check_trap_enable(check_trap_enable),
	.arch_present(arch_present), .msr_rd(msr_rd), .msr_wr(msr_wr), .msr_addr(msr_addr),
	.msr_wdata(msr_wdata), .exc_done(exc_done), .msr_rdata(msr_rdata), .msr_rvalid(msr_rvalid),
	.mc_exception(mc_exception), .exception_in_progress_flag(exception_in_progress_flag));

// file: mcb_top_tb_top.sv
`timescale 1ns/1ps
module mcb_top_tb_top;
	localparam NB = 4;
	reg          core_clk = 0, srst = 1, nf = 0, ctx = 0, hl = 0, he = 0, rok = 0;
	reg          trap = 0, arch = 0, msr_rd = 0, msr_wr = 0, exc_done = 0;
	reg [NB-1:0] ev = 0;
	reg [15:0]   code = 0;
	reg [63:0]   loc = 0, ext = 0, wd = 0;
	reg [11:0]   ad = 0;
	wire [63:0]  rdata;
	wire         rv, exc, inp, rst_ok;
	integer      fails = 0, total_checks = 0;
	initial forever #2 core_clk = ~core_clk;
	mcb_top #(.NBANK(NB)) uut (.core_clk(core_clk), .srst(srst), .err_valid(ev),
		.err_not_fixed(nf), .err_ctx_bad(ctx), .err_has_loc(hl), .err_has_extra(he),
		.err_code(code), .err_loc(loc), .err_extra(ext), .err_restart_ok(rok),
		.check_trap_enable(trap), .arch_present(arch), .msr_rd(msr_rd), .msr_wr(msr_wr),
		.msr_addr(ad), .msr_wdata(wd), .exc_done(exc_done), .msr_rdata(rdata),
		.msr_rvalid(rv), .mc_exception(exc), .exception_in_progress_flag(inp),
		.restartable(rst_ok));
	task chk(input [63:0] g, input [63:0] e);
		total_checks = total_checks + 1;
		if (g !== e)
		begin
			fails = fails + 1;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// tasks start at a falling edge and end at one, so calls run back to back
	task rd(input [11:0] a, input [63:0] e);
		msr_rd = 1; ad = a;
		@(negedge core_clk); msr_rd = 0;
		chk(rv, 1); chk(rdata, e);
	endtask
	task wr(input [11:0] a, input [63:0] d);
		msr_wr = 1; ad = a; wd = d;
		@(negedge core_clk); msr_wr = 0;
	endtask
	// q is {not_fixed, ctx_bad, has_loc, has_extra, restart_ok}
	task err(input [NB-1:0] b, input [4:0] q, input [15:0] c);
		ev = b; {nf, ctx, hl, he, rok} = q; code = c; loc = {4{c}}; ext = ~loc;
		@(negedge core_clk); ev = 0;
		chk(exc, q[4]);
	endtask
	function [63:0] st(input [4:0] q, input lost, input [15:0] c);
		st = {1'b1, lost, q[4], 1'b0, q[1], q[2], q[3], 41'h0, c};
	endfunction
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// whole sequence needs well under 100 cycles
	initial
	begin
		#4000 fails = fails + 1;
		give_verdict;
	end
	initial
	begin
		repeat (8) @(negedge core_clk);
		srst = 0;
		rd(12'h000, 0);
		rd(12'h400, 0);
		err(4'h2, 5'b00110, 16'h0011);
		rd(12'h405, st(5'b00110, 0, 16'h0011));
		rd(12'h406, {4{16'h0011}});
		rd(12'h407, ~{4{16'h0011}});
		err(4'h2, 5'b00000, 16'h0022);
		rd(12'h405, st(5'b00110, 1, 16'h0011));
		rd(12'h406, {4{16'h0011}});
		wr(12'h405, 64'h1);
		rd(12'h405, st(5'b00110, 1, 16'h0011));
		wr(12'h405, 0);
		@(negedge core_clk);
		rd(12'h405, 0);
		err(4'h2, 5'b11000, 16'h0033);
		chk(inp, 1);
		chk(rst_ok, 0);
		rd(12'h405, st(5'b11000, 0, 16'h0033));
		exc_done = 1;
		@(negedge core_clk); exc_done = 0;
		chk(inp, 0);
		err(4'h4, 5'b10001, 16'h0044);
		chk(rst_ok, 1);
		rd(12'h17A, 64'h5);
		err(4'h1, 5'b00000, 16'h0055);
		wr(12'h401, 0);
		rd(12'h401, 0);
		arch = 1;
		rd(12'h179, 64'h200 | NB);
		trap = 1;
		rd(12'h001, 0);
		give_verdict;
	end
endmodule
